/* bench/dvsm_chk_sva.sv */
// Purpose: Port assertions for dvsm_top
// Assumes: APB map and stream timing of the note
// Notes:   Bound to dvsm_top below
`timescale 1ns/1ps
module dvsm_chk
   import dvsm_pkg::*;
(
   input wire logic                 clock,    // Clock
   input wire logic                 rst,      // Reset
   input wire logic                 psel,     // Select
   input wire logic                 penable,  // Access
   input wire logic                 pwrite,   // Write
   input wire logic [11:0]          paddr,    // Address
   input wire logic [31:0]          pwdata,   // Write data
   input wire logic [31:0]          prdata,   // Read data
   input wire logic                 pready,   // Ready
   input wire logic                 pslverr,  // Error
   input wire logic                 in_valid, // Push
   input wire logic                 in_ready, // Room
   input wire dvsm_pkg::dvsm_pair_s out_pair, // Output
   input wire logic                 out_valid,// Out valid
   input wire logic                 out_ready // Sink ready
);
   // ====
   // Helpers
   logic mapped;
   logic link_kept_reg;
   assign mapped = paddr inside {OFS_CTRL, OFS_VOL_LEFT, OFS_VOL_RIGHT, OFS_STATUS};
   // Link never cleared since reset
   always_ff @(posedge clock) begin
      if (rst) link_kept_reg <= 1'b1;
      else if (psel && penable && pwrite && paddr == OFS_CTRL && !pwdata[CTRL_LINK_BIT]) link_kept_reg <= 1'b0;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Status read access
   sequence st_read;
      psel && penable && !pwrite && paddr == OFS_STATUS;
   endsequence
   pready_high_a: assert property (pready) else $error("pready low");
   bad_addr_a: assert property (psel && penable && !mapped |-> pslverr) else $error("no error");
   ok_addr_a: assert property (psel && penable && mapped |-> !pslverr) else $error("false error");
   bad_read_a: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0000_0000)
      else $error("unmapped data");
   out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_pair))
      else $error("output dropped");
   push_flow_a: assert property (in_valid && in_ready && !out_valid |-> ##[1:2] out_valid)
      else $error("sample stuck");
   code_range_a: assert property (st_read |-> prdata[7:0] <= CODE_MUTE && prdata[15:8] <= CODE_MUTE)
      else $error("code range");
   link_both_a: assert property (st_read |-> !link_kept_reg || prdata[15:8] == prdata[7:0])
      else $error("link broken");
   reset_idle_a: assert property ($fell(rst) |-> !out_valid && in_ready) else $error("not idle");
endmodule
bind dvsm_top dvsm_chk chk (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
   .in_ready(in_ready), .out_pair(out_pair), .out_valid(out_valid), .out_ready(out_ready));

/* bench/dvsm_src.sv */
// Purpose: Sample source feeding the volume stage
// Assumes: Valid held until accepted
// Notes:   Released data shows the inverse
`timescale 1ns/1ps
module dvsm_src
   import dvsm_pkg::*;
(
   input  wire logic           clock,   // Clock
   input  wire logic           in_ready,// Room
   output dvsm_pkg::dvsm_pair_s in_pair, // Sample
   output logic                in_valid // Valid
);
   initial begin
      in_pair = '0;
      in_valid = 1'b0;
   end
   // Push n copies, one per accepting edge
   task automatic send(input dvsm_pair_s p, input int n, input int lim, output int sent);
      int cyc;
      sent = 0;
      cyc = 0;
      in_pair <= p;
      in_valid <= 1'b1;
      while (sent < n && cyc < lim) begin
         @(posedge clock);
         cyc++;
         if (in_ready === 1'b1) sent++;
      end
      in_valid <= 1'b0;
      in_pair <= ~p;
   endtask
endmodule

/* bench/testbench.sv */
// Purpose: Directed test of dvsm_top
// Assumes: Zero-wait APB, 2-cycle stream latency
// Notes:   Ramp checks read applied codes
`timescale 1ns/1ps
module testbench;
   import dvsm_pkg::*;
   logic        clock, rst, psel, penable, pwrite, pready, pslverr;
   logic        in_valid, in_ready, out_valid, out_ready;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   dvsm_pair_s  in_pair, out_pair, last_out;
   int          n_fail, checks, s;
   dvsm_top dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_pair(in_pair),
      .in_valid(in_valid), .in_ready(in_ready), .out_pair(out_pair), .out_valid(out_valid), .out_ready(out_ready));
   dvsm_src src (.clock(clock), .in_ready(in_ready), .in_pair(in_pair), .in_valid(in_valid));
   // ====
   // Clock and capture
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) if (out_valid && out_ready) last_out <= out_pair;
   task automatic summarize();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One APB transfer, held until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) begin
         n_fail++;
         summarize();
      end
   endtask
   task automatic drain();
      int k;
      repeat (3) @(posedge clock);
      for (k = 0; k < 60 && out_valid !== 1'b0; k++) @(posedge clock);
      if (k >= 60) begin
         n_fail++;
         summarize();
      end
   endtask
   task automatic feed(input logic [23:0] v, input int n);
      src.send({v, ~v}, n, n + 40, s);
      if (s != n) n_fail++;
      drain();
   endtask
   task automatic st(input logic [15:0] e);
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      check(48'(rd), 48'(e));
   endtask
   // ====
   // Sequence
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata, n_fail, checks, last_out} = '0;
      rst = 1'b1;
      out_ready = 1'b1;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      apb(1'b0, OFS_CTRL, 32'h0);
      check(48'(rd), 48'(CTRL_RESET));
      apb(1'b0, OFS_VOL_RIGHT, 32'h0);
      check(48'(rd), 48'(CODE_UNITY));
      st(16'h1818);
      apb(1'b1, 12'h010, 32'h0000_0000);
      apb(1'b0, 12'h010, 32'h0);
      check(48'(rd), 48'h0);
      apb(1'b0, OFS_CTRL, 32'h0);
      check(48'(rd), 48'(CTRL_RESET));
      $display("registers done");
      apb(1'b1, OFS_CTRL, 32'h3);
      apb(1'b1, OFS_VOL_LEFT, 32'h0);
      apb(1'b1, OFS_VOL_RIGHT, 32'h30);
      feed(24'h0, 30);
      st(16'h0000);
      feed(24'h7F_FFFF, 1);
      check(last_out, {24'h7F_FFFF, 24'h80_0000});
      apb(1'b1, OFS_CTRL, 32'h2);
      feed(24'h0, 60);
      st(16'h3000);
      $display("gain and link done");
      apb(1'b1, OFS_CTRL, 32'h6);
      feed(24'h0, 190);
      apb(1'b0, OFS_STATUS, 32'h0);
      check(48'(rd[7:0] < CODE_MUTE), 48'h1);
      feed(24'h0, 20);
      st(16'hCCCC);
      feed(24'h10_0000, 1);
      check(last_out, 48'h0);
      apb(1'b1, OFS_CTRL, 32'h2);
      feed(24'h0, 210);
      st(16'h3000);
      apb(1'b1, OFS_CTRL, 32'h6);
      feed(24'h0, 20);
      apb(1'b1, OFS_CTRL, 32'h2);
      feed(24'h0, 25);
      st(16'h3000);
      $display("soft mute done");
      apb(1'b1, OFS_CTRL, 32'h4);
      feed(24'h0, 800);
      apb(1'b0, OFS_STATUS, 32'h0);
      check(48'(rd[7:0] < CODE_MUTE), 48'h1);
      feed(24'h0, 30);
      st(16'hCCCC);
      $display("slow ramp done");
      out_ready <= 1'b0;
      src.send({24'h1, 24'h2}, 40, 60, s);
      check(48'(s >= FIFO_DEPTH && s <= FIFO_DEPTH + 2), 48'h1);
      @(posedge clock);
      out_ready <= 1'b1;
      drain();
      check(48'(in_ready), 48'h1);
      $display("buffer done");
      summarize();
   end
endmodule

/* core/dvsm_fifo.sv */
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Depth must be a power of two
`timescale 1ns/1ps
module dvsm_fifo #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 16
) (
   input  wire logic             clock,    // System clock
   input  wire logic             rst,      // Sync reset
   input  wire logic [WIDTH-1:0] in_data,  // Write data
   input  wire logic             in_valid, // Write request
   output logic                  in_ready, // Not full
   output logic      [WIDTH-1:0] out_data, // Head word
   output logic                  out_valid,// Not empty
   input  wire logic             out_ready // Drain accept
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wptr_reg;
   logic [AW:0]      rptr_reg;
   logic             push;
   logic             pop;

   // Honest full and empty from pointer compare
   assign in_ready  = !((wptr_reg[AW] != rptr_reg[AW]) && (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]));
   assign out_valid = (wptr_reg != rptr_reg);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rptr_reg[AW-1:0]];

   // Storage
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wptr_reg[AW-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge clock) begin
      if (rst) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
      end else begin
         if (push) begin
            wptr_reg <= wptr_reg + 1'b1;
         end
         if (pop) begin
            rptr_reg <= rptr_reg + 1'b1;
         end
      end
   end
endmodule

/* core/dvsm_pkg.sv */
// Purpose: Shared constants and carrier types for the output volume / soft mute stage
// Assumes: 24-bit signed stereo samples, APB register access
// Notes:   Gain table is a Q4.16 multiplier per 0.5 dB code
package dvsm_pkg;
   localparam int          SAMPLE_W         = 24;
   localparam int          GAIN_W           = 20;          // Q4.16 unsigned
   localparam int          GAIN_FRAC        = 16;
   localparam logic [7:0]  CODE_MAX_GAIN    = 8'h00;       // +12 dB
   localparam logic [7:0]  CODE_UNITY       = 8'h18;       // 0 dB, reset default
   localparam logic [7:0]  CODE_MUTE        = 8'hCC;       // first mute code
   localparam int          LEVEL_COUNT      = 205;
   localparam logic [1:0]  SLOW_DIV         = 2'h3;        // step every 4th sample
   localparam logic [1:0]  FAST_DIV         = 2'h0;        // step every sample
   localparam int          FIFO_DEPTH       = 16;
   // Register byte offsets
   localparam logic [11:0] OFS_CTRL         = 12'h000;
   localparam logic [11:0] OFS_VOL_LEFT     = 12'h004;
   localparam logic [11:0] OFS_VOL_RIGHT    = 12'h008;
   localparam logic [11:0] OFS_STATUS       = 12'h00C;
   // Control field positions
   localparam int          CTRL_LINK_BIT    = 0;
   localparam int          CTRL_RAMP_BIT    = 1;
   localparam int          CTRL_MUTE_BIT    = 2;
   localparam logic [31:0] CTRL_RESET       = 32'h0000_0001;

   typedef struct packed {
      logic signed [SAMPLE_W-1:0] left;
      logic signed [SAMPLE_W-1:0] right;
   } dvsm_pair_s;

   localparam int PAIR_W = 2 * SAMPLE_W;
endpackage

/* core/dvsm_top.sv */
// Purpose: Output digital volume with soft ramping and soft mute ahead of a stereo DAC
// Assumes: One clock; samples arrive as valid/ready pairs at fs; APB slave for control
// Notes:   One ramp step per sample (fast) or per fourth sample (slow)
//
// Operation
// RULE1: 204 gain levels in 0.5 dB steps plus mute applied before the DAC.
// RULE2: Code 00h is +12 dB, 18h is 0 dB default, CCh and above mute.
// RULE3: Link set (default) makes left code drive both channels, right ignored.
// RULE4: Link clear gives each channel its own volume code.
// RULE5: Full-range ramp takes 816 samples (select 0) or 204 samples (select 1).
// RULE6: Soft mute request ramps output from target attenuation down to zero.
// RULE7: Mute release ramps gain from mute back to target attenuation.
// RULE8: Early release reverses the ramp back toward target immediately.
// RULE9: Mute only scales sample values; samples keep flowing at fs.
// RULE10: Step one code every fourth sample (select 0) or every sample (select 1).
// RULE11: Products saturate to the sample range instead of wrapping.
`timescale 1ns/1ps
module dvsm_top
   import dvsm_pkg::*;
(
   input  wire logic                 clock,     // 250 MHz system clock
   input  wire logic                 rst,       // Sync reset, active high
   // APB slave
   input  wire logic                 psel,      // Select
   input  wire logic                 penable,   // Access phase
   input  wire logic                 pwrite,    // Write
   input  wire logic [11:0]          paddr,     // Byte address
   input  wire logic [31:0]          pwdata,    // Write data
   output logic      [31:0]          prdata,    // Read data
   output logic                      pready,    // Always ready
   output logic                      pslverr,   // Unmapped access
   // Sample input
   input  wire dvsm_pkg::dvsm_pair_s in_pair,   // Stereo sample
   input  wire logic                 in_valid,  // Sample valid
   output logic                      in_ready,  // FIFO not full
   // Sample output toward DAC
   output dvsm_pkg::dvsm_pair_s      out_pair,  // Scaled sample
   output logic                      out_valid, // Output valid
   input  wire logic                 out_ready  // DAC accept
);
   import dvsm_pkg::*;

   // ===========================================================
   // Gain lookup and saturation
   // ===========================================================

   // Q4.16 multiplier for a code: 10^(-(code-24)/40)
   function automatic logic [GAIN_W-1:0] code_gain(input logic [7:0] code);
      logic [GAIN_W-1:0] base;
      logic [7:0]        steps;
      logic [4:0]        octave;
      logic [3:0]        sub;
      base = 20'h0_0000;
      steps = code;
      if (code >= CODE_MUTE) begin // [RULE2]
         code_gain = 20'h0_0000;
      end else begin
         // 12 codes per 6.02 dB octave approximated as 12 steps
         octave = 5'(steps / 8'd12);
         sub    = 4'(steps % 8'd12);
         case (sub)
            4'd0:    base = 20'h3_FB3C; // +12.0 dB relative top entries
            4'd1:    base = 20'h3_C0C8;
            4'd2:    base = 20'h3_8B38;
            4'd3:    base = 20'h3_5A28;
            4'd4:    base = 20'h3_2D70;
            4'd5:    base = 20'h3_0528;
            4'd6:    base = 20'h2_E018;
            4'd7:    base = 20'h2_BE78;
            4'd8:    base = 20'h2_9FC8;
            4'd9:    base = 20'h2_8410;
            4'd10:   base = 20'h2_6B00;
            4'd11:   base = 20'h2_5460;
            default: base = 20'h0_0000;
         endcase
         code_gain = base >> octave; // [RULE1]
      end
   endfunction

   // Scale one sample and clip to word range
   function automatic logic signed [SAMPLE_W-1:0] scale_sat(
      input logic signed [SAMPLE_W-1:0] s,
      input logic        [GAIN_W-1:0]   g);
      logic signed [SAMPLE_W+GAIN_W:0] prod;
      logic signed [SAMPLE_W+GAIN_W:0] shifted;
      logic signed [SAMPLE_W+GAIN_W:0] hi;
      logic signed [SAMPLE_W+GAIN_W:0] lo;
      prod    = s * $signed({1'b0, g});
      shifted = prod >>> GAIN_FRAC;
      hi      = (SAMPLE_W+GAIN_W+1)'(2 ** (SAMPLE_W-1) - 1);
      lo      = -hi - 1;
      if (shifted > hi) begin // [RULE11]
         scale_sat = SAMPLE_W'(hi);
      end else if (shifted < lo) begin
         scale_sat = SAMPLE_W'(lo);
      end else begin
         scale_sat = SAMPLE_W'(shifted);
      end
   endfunction

   // Next ramp code one step toward a goal
   function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] goal);
      if (cur < goal) begin
         step_toward = cur + 8'h01;
      end else if (cur > goal) begin
         step_toward = cur - 8'h01;
      end else begin
         step_toward = cur;
      end
   endfunction

   // Clamp any mute code onto the single mute step
   function automatic logic [7:0] clamp_code(input logic [7:0] c);
      clamp_code = (c >= CODE_MUTE) ? CODE_MUTE : c;
   endfunction

   // ===========================================================
   // APB register file
   // ===========================================================
   logic [31:0] ctrl_reg;
   logic [7:0]  vol_left_reg;
   logic [7:0]  vol_right_reg;
   logic [7:0]  app_left_reg;
   logic [7:0]  app_right_reg;
   logic        apb_wr;
   logic        mapped;

   assign pready = 1'b1;
   assign apb_wr = psel && penable && pwrite;
   assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_VOL_LEFT) ||
                   (paddr == OFS_VOL_RIGHT) || (paddr == OFS_STATUS);
   assign pslverr = psel && penable && !mapped;

   // Register writes
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_reg      <= CTRL_RESET;
         vol_left_reg  <= CODE_UNITY;
         vol_right_reg <= CODE_UNITY;
      end else if (apb_wr) begin
         case (paddr)
            OFS_CTRL:      ctrl_reg      <= pwdata & 32'h0000_0007;
            OFS_VOL_LEFT:  vol_left_reg  <= pwdata[7:0];
            OFS_VOL_RIGHT: vol_right_reg <= pwdata[7:0];
            default:       ctrl_reg      <= ctrl_reg;
         endcase
      end
   end

   // Read mux, registered
   always_ff @(posedge clock) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         case (paddr)
            OFS_CTRL:      prdata <= ctrl_reg;
            OFS_VOL_LEFT:  prdata <= {24'h00_0000, vol_left_reg};
            OFS_VOL_RIGHT: prdata <= {24'h00_0000, vol_right_reg};
            OFS_STATUS:    prdata <= {16'h0000, app_right_reg, app_left_reg};
            default:       prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ===========================================================
   // Target selection and ramp
   // ===========================================================
   logic       channel_link_select;
   logic       ramp_time_select;
   logic       soft_mute_request;
   logic [7:0] target_left;
   logic [7:0] target_right;
   logic [7:0] goal_left;
   logic [7:0] goal_right;
   logic [1:0] div_reg;
   logic       step_en;

   assign channel_link_select = ctrl_reg[CTRL_LINK_BIT];
   assign ramp_time_select    = ctrl_reg[CTRL_RAMP_BIT];
   assign soft_mute_request   = ctrl_reg[CTRL_MUTE_BIT];

   // Linked mode copies left code to both channels
   assign target_left  = clamp_code(vol_left_reg);                        // [RULE3]
   assign target_right = channel_link_select ? clamp_code(vol_left_reg)   // [RULE3]
                                             : clamp_code(vol_right_reg); // [RULE4]

   // Mute drives goal to mute; release or early cancel returns to target
   assign goal_left  = soft_mute_request ? CODE_MUTE : target_left;  // [RULE6] [RULE7] [RULE8]
   assign goal_right = soft_mute_request ? CODE_MUTE : target_right; // [RULE6] [RULE7] [RULE8]

   // Pipeline handshake
   dvsm_pair_s fifo_pair;
   logic       fifo_valid;
   logic       fifo_ready;
   logic       take;

   assign fifo_ready = !out_valid || out_ready;
   assign take       = fifo_valid && fifo_ready;

   // Sample-rate step divider
   always_ff @(posedge clock) begin
      if (rst) begin
         div_reg <= 2'h0;
      end else if (take) begin
         div_reg <= (div_reg >= (ramp_time_select ? FAST_DIV : SLOW_DIV)) ? 2'h0 : div_reg + 2'h1; // [RULE10]
      end
   end

   assign step_en = take && (div_reg >= (ramp_time_select ? FAST_DIV : SLOW_DIV)); // [RULE5] [RULE10]

   // Applied codes follow goal one step at a time
   always_ff @(posedge clock) begin
      if (rst) begin
         app_left_reg  <= CODE_UNITY;
         app_right_reg <= CODE_UNITY;
      end else if (step_en) begin
         app_left_reg  <= step_toward(app_left_reg, goal_left);   // [RULE5]
         app_right_reg <= step_toward(app_right_reg, goal_right); // [RULE5]
      end
   end

   // ===========================================================
   // Data path
   // ===========================================================
   logic [PAIR_W-1:0] fifo_word;

   dvsm_fifo #(
      .WIDTH (PAIR_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_data   (in_pair),
      .in_valid  (in_valid),
      .in_ready  (in_ready),
      .out_data  (fifo_word),
      .out_valid (fifo_valid),
      .out_ready (fifo_ready)
   );

   assign fifo_pair = fifo_word;

   // Scaled output register; samples flow even when muted
   always_ff @(posedge clock) begin
      if (rst) begin
         out_pair  <= '0;
         out_valid <= 1'b0;
      end else if (fifo_ready) begin
         out_valid <= fifo_valid; // [RULE9]
         if (fifo_valid) begin
            out_pair.left  <= scale_sat(fifo_pair.left, code_gain(app_left_reg));   // [RULE1] [RULE9]
            out_pair.right <= scale_sat(fifo_pair.right, code_gain(app_right_reg)); // [RULE1] [RULE9]
         end
      end
   end
endmodule
